// ===== core/nidly_regs.sv
// AXI4-Lite register bank for lane 1 and lane 2 input delay taps.
`timescale 1ns/100ps
`include "nidly_params.svh"
module nidly_regs (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [`NIDLY_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [`NIDLY_DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [`NIDLY_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [`NIDLY_DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic [`NIDLY_BUS_W-1:0]    fabric_tap_load_bus,
  input  wire logic [1:0]                 fabric_load_en,
  output logic [`NIDLY_BUS_W-1:0]         fabric_tap_readback_bus,
  input  wire logic [1:0]                 align_load_en,
  input  wire logic [2*`NIDLY_TAP_W-1:0]  align_offset_bus,
  output logic [2*`NIDLY_TAP_W-1:0]       align_offset_out
);

  // Write channel state.
  logic                       aw_held_r;
  logic                       w_held_r;
  logic [`NIDLY_ADDR_W-1:0]   awaddr_r;
  logic [`NIDLY_DATA_W-1:0]   wdata_r;
  logic [3:0]                 wstrb_r;
  logic                       awready_r;
  logic                       wready_r;
  logic                       bvalid_r;
  logic [1:0]                 bresp_r;
  logic                       aw_hs;
  logic                       w_hs;
  logic                       commit;
  logic                       aw_held_nxt;
  logic                       w_held_nxt;
  logic                       bvalid_nxt;

  // Read channel state.
  logic                       arready_r;
  logic                       rvalid_r;
  logic [`NIDLY_DATA_W-1:0]   rdata_r;
  logic [1:0]                 rresp_r;
  logic                       ar_hs;
  logic                       rvalid_nxt;

  // Register contents and decode.
  nidly_pkg::nidly_tap_t      coarse_r;
  nidly_pkg::nidly_tap_t      slice1_tap_value;
  nidly_pkg::nidly_tap_t      slice2_tap_value;
  nidly_pkg::nidly_tap_t      slice1_align;
  nidly_pkg::nidly_tap_t      slice2_align;
  nidly_pkg::nidly_sel_e      wr_sel;
  nidly_pkg::nidly_sel_e      rd_sel;
  nidly_pkg::nidly_tap_t      wr_old;
  nidly_pkg::nidly_tap_t      wr_merged;
  logic [2:0]                 wr_code;
  logic                       slice1_wr;
  logic                       slice2_wr;

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  assign aw_hs  = s_axi_awvalid && awready_r;
  assign w_hs   = s_axi_wvalid && wready_r;
  assign ar_hs  = s_axi_arvalid && arready_r;
  // Address and data are held separately, so the master may offer them in
  // either order; the write is applied one cycle after both are in.
  assign commit = aw_held_r && w_held_r && !bvalid_r;

  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    bvalid_nxt  = bvalid_r;
    if (commit) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
    end else begin
      if (aw_hs) begin
        aw_held_nxt = 1'b1;
      end
      if (w_hs) begin
        w_held_nxt = 1'b1;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      bvalid_r  <= bvalid_nxt;
      // Ready drops while a beat is held or a response waits, which keeps
      // just one write in flight.
      awready_r <= !aw_held_nxt && !bvalid_nxt;
      wready_r  <= !w_held_nxt && !bvalid_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_r <= '0;
    end else if (aw_hs) begin
      awaddr_r <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdata_r <= '0;
      wstrb_r <= 4'h0;
    end else if (w_hs) begin
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp_r <= `NIDLY_RESP_OKAY;
    end else if (commit) begin
      bresp_r <= (wr_sel == nidly_pkg::NIDLY_SEL_NONE) ?
                 `NIDLY_RESP_SLVERR : `NIDLY_RESP_OKAY;
    end
  end

  // Write decode. Unstrobed lanes keep the current value; without lane 1
  // the action bits count as zero, so the write is a plain load.
  assign wr_sel = nidly_pkg::nidly_addr_sel(awaddr_r);

  always_comb begin
    case (wr_sel)
      nidly_pkg::NIDLY_SEL_SLICE1: wr_old = slice1_tap_value;
      nidly_pkg::NIDLY_SEL_SLICE2: wr_old = slice2_tap_value;
      nidly_pkg::NIDLY_SEL_COARSE: wr_old = coarse_r;
      default:                     wr_old = `NIDLY_TAP_RST;
    endcase
  end

  always_comb begin
    wr_merged = wr_old;
    wr_code   = `NIDLY_CODE_NONE;
    if (wstrb_r[0]) begin
      wr_merged[`NIDLY_LANE0_MSB:0] = wdata_r[`NIDLY_LANE0_MSB:0];
    end
    if (wstrb_r[1]) begin
      wr_merged[`NIDLY_VAL_MSB] = wdata_r[`NIDLY_VAL_MSB];
      wr_code = {wdata_r[`NIDLY_CRSE_BIT], wdata_r[`NIDLY_DEC_BIT],
                 wdata_r[`NIDLY_INC_BIT]};
    end
  end

  // Bits 12 to 9 of the written word reach no storage.
  assign slice1_wr = commit && (wr_sel == nidly_pkg::NIDLY_SEL_SLICE1);
  assign slice2_wr = commit && (wr_sel == nidly_pkg::NIDLY_SEL_SLICE2);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coarse_r <= `NIDLY_COARSE_RST;
    end else if (commit && (wr_sel == nidly_pkg::NIDLY_SEL_COARSE)) begin
      coarse_r <= wr_merged;
    end
  end

  nidly_tap_unit u_slice1 (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .wr_en        (slice1_wr),
    .wr_code      (wr_code),
    .wr_value     (wr_merged),
    .coarse_step  (coarse_r),
    .fab_load     (fabric_load_en[0]),
    .fab_value    (fabric_tap_load_bus[`NIDLY_S1_MSB:`NIDLY_S1_LSB]),
    .align_load   (align_load_en[0]),
    .align_value  (align_offset_bus[`NIDLY_TAP_W-1:0]),
    .tap_value    (slice1_tap_value),
    .align_offset (slice1_align)
  );

  nidly_tap_unit u_slice2 (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .wr_en        (slice2_wr),
    .wr_code      (wr_code),
    .wr_value     (wr_merged),
    .coarse_step  (coarse_r),
    .fab_load     (fabric_load_en[1]),
    .fab_value    (fabric_tap_load_bus[`NIDLY_S2_MSB:`NIDLY_S2_LSB]),
    .align_load   (align_load_en[1]),
    .align_value  (align_offset_bus[2*`NIDLY_TAP_W-1:`NIDLY_TAP_W]),
    .tap_value    (slice2_tap_value),
    .align_offset (slice2_align)
  );

  // Both buses come straight from the tap and offset flops; lane 0 is not here.
  assign fabric_tap_readback_bus = {slice2_tap_value,
                                    slice1_tap_value,
                                    `NIDLY_TAP_RST};
  assign align_offset_out = {slice2_align, slice1_align};

  // Read path.
  assign rd_sel = nidly_pkg::nidly_addr_sel(s_axi_araddr);

  always_comb begin
    rvalid_nxt = rvalid_r;
    if (ar_hs) begin
      rvalid_nxt = 1'b1;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b0;
    end else begin
      rvalid_r  <= rvalid_nxt;
      arready_r <= !rvalid_nxt;
    end
  end

  // The live tap is returned, which already carries the alignment offset;
  // action and reserved bits read as zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_r <= '0;
      rresp_r <= `NIDLY_RESP_OKAY;
    end else if (ar_hs) begin
      rdata_r <= '0;
      rresp_r <= `NIDLY_RESP_OKAY;
      case (rd_sel)
        nidly_pkg::NIDLY_SEL_SLICE1:
          rdata_r[`NIDLY_VAL_MSB:0] <= slice1_tap_value;
        nidly_pkg::NIDLY_SEL_SLICE2:
          rdata_r[`NIDLY_VAL_MSB:0] <= slice2_tap_value;
        nidly_pkg::NIDLY_SEL_COARSE:
          rdata_r[`NIDLY_VAL_MSB:0] <= coarse_r;
        default:
          rresp_r <= `NIDLY_RESP_SLVERR;
      endcase
    end
  end

endmodule : nidly_regs

// ===== core/nidly_params.svh
// Constants for the nibble input delay register bank.
`ifndef NIDLY_PARAMS_SVH
`define NIDLY_PARAMS_SVH

`define NIDLY_ADDR_W      8
`define NIDLY_DATA_W      32
`define NIDLY_TAP_W       9
`define NIDLY_IDX_MSB     7
`define NIDLY_IDX_LSB     2
`define NIDLY_IDX_SLICE1  6'h13
`define NIDLY_IDX_SLICE2  6'h14
`define NIDLY_IDX_COARSE  6'h20
`define NIDLY_VAL_MSB     8
`define NIDLY_LANE0_MSB   7
`define NIDLY_CODE_LSB    13
`define NIDLY_CODE_MSB    15
`define NIDLY_CRSE_BIT    13
`define NIDLY_DEC_BIT     14
`define NIDLY_INC_BIT     15
`define NIDLY_CODE_NONE   3'h0
`define NIDLY_TAP_RST     9'h000
`define NIDLY_ALIGN_RST   9'h000
`define NIDLY_COARSE_RST  9'h000
`define NIDLY_TAP_ONE     9'h001
`define NIDLY_BUS_W       27
`define NIDLY_S1_LSB      9
`define NIDLY_S1_MSB      17
`define NIDLY_S2_LSB      18
`define NIDLY_S2_MSB      26
`define NIDLY_RESP_OKAY   2'h0
`define NIDLY_RESP_SLVERR 2'h2

`endif

// ===== core/nidly_pkg.sv
// Types and shared decode functions for the nibble input delay bank.
`include "nidly_params.svh"
package nidly_pkg;

  typedef logic [`NIDLY_TAP_W-1:0] nidly_tap_t;

  typedef enum logic [2:0] {
    NIDLY_ACT_LOAD    = 3'h0,
    NIDLY_ACT_INC     = 3'h1,
    NIDLY_ACT_DEC     = 3'h2,
    NIDLY_ACT_CRS_UP  = 3'h3,
    NIDLY_ACT_CRS_DN  = 3'h4
  } nidly_act_e;

  typedef enum logic [1:0] {
    NIDLY_SEL_NONE   = 2'h0,
    NIDLY_SEL_SLICE1 = 2'h1,
    NIDLY_SEL_SLICE2 = 2'h2,
    NIDLY_SEL_COARSE = 2'h3
  } nidly_sel_e;

  // Code is {coarse, step_down, step_up}.
  function automatic nidly_act_e nidly_decode_act(input logic [2:0] code);
    case (code)
      3'h1:    nidly_decode_act = NIDLY_ACT_INC;
      3'h2:    nidly_decode_act = NIDLY_ACT_DEC;
      3'h5:    nidly_decode_act = NIDLY_ACT_CRS_UP;
      3'h6:    nidly_decode_act = NIDLY_ACT_CRS_DN;
      default: nidly_decode_act = NIDLY_ACT_LOAD;
    endcase
  endfunction : nidly_decode_act

  function automatic nidly_sel_e nidly_addr_sel(
    input logic [`NIDLY_ADDR_W-1:0] addr
  );
    logic [`NIDLY_IDX_MSB-`NIDLY_IDX_LSB:0] idx;
    idx = addr[`NIDLY_IDX_MSB:`NIDLY_IDX_LSB];
    if (addr[`NIDLY_IDX_LSB-1:0] != 2'h0) begin
      nidly_addr_sel = NIDLY_SEL_NONE;
    end else if (idx == `NIDLY_IDX_SLICE1) begin
      nidly_addr_sel = NIDLY_SEL_SLICE1;
    end else if (idx == `NIDLY_IDX_SLICE2) begin
      nidly_addr_sel = NIDLY_SEL_SLICE2;
    end else if (idx == `NIDLY_IDX_COARSE) begin
      nidly_addr_sel = NIDLY_SEL_COARSE;
    end else begin
      nidly_addr_sel = NIDLY_SEL_NONE;
    end
  endfunction : nidly_addr_sel

endpackage : nidly_pkg

// ===== core/nidly_tap_unit.sv
// One four-bit lane's tap value with its alignment offset.
`timescale 1ns/100ps
`include "nidly_params.svh"
module nidly_tap_unit (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   wr_en,
  input  wire logic [2:0]             wr_code,
  input  wire nidly_pkg::nidly_tap_t  wr_value,
  input  wire nidly_pkg::nidly_tap_t  coarse_step,
  input  wire logic                   fab_load,
  input  wire nidly_pkg::nidly_tap_t  fab_value,
  input  wire logic                   align_load,
  input  wire nidly_pkg::nidly_tap_t  align_value,
  output nidly_pkg::nidly_tap_t       tap_value,
  output nidly_pkg::nidly_tap_t       align_offset
);

  nidly_pkg::nidly_tap_t tap_r;
  nidly_pkg::nidly_tap_t tap_nxt;
  nidly_pkg::nidly_tap_t align_r;
  nidly_pkg::nidly_act_e act;

  assign act          = nidly_pkg::nidly_decode_act(wr_code);
  assign tap_value    = tap_r;
  assign align_offset = align_r;

  // Register writes win over the fabric port, which wins over an
  // alignment update, so one cycle never mixes two sources.
  always_comb begin
    tap_nxt = tap_r;
    if (wr_en) begin
      case (act)
        nidly_pkg::NIDLY_ACT_INC:
          tap_nxt = nidly_pkg::nidly_tap_t'(tap_r + `NIDLY_TAP_ONE);
        nidly_pkg::NIDLY_ACT_DEC:
          tap_nxt = nidly_pkg::nidly_tap_t'(tap_r - `NIDLY_TAP_ONE);
        nidly_pkg::NIDLY_ACT_CRS_UP:
          tap_nxt = nidly_pkg::nidly_tap_t'(tap_r + coarse_step);
        nidly_pkg::NIDLY_ACT_CRS_DN:
          tap_nxt = nidly_pkg::nidly_tap_t'(tap_r - coarse_step);
        default:
          tap_nxt = wr_value;
      endcase
    end else if (fab_load) begin
      tap_nxt = fab_value;
    end else if (align_load) begin
      // The tap carries the offset, so a new offset shifts it by the change.
      tap_nxt = nidly_pkg::nidly_tap_t'(tap_r - align_r
                                        + align_value);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tap_r <= `NIDLY_TAP_RST;
    end else begin
      tap_r <= tap_nxt;
    end
  end

  // Only the alignment strobe touches the offset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      align_r <= `NIDLY_ALIGN_RST;
    end else if (align_load) begin
      align_r <= align_value;
    end
  end

endmodule : nidly_tap_unit

// ===== verification/nidly_regs_asserts.sv
// Port-level assertions for the nibble input delay register bank.
`timescale 1ns/100ps
module nidly_regs_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [26:0] fabric_tap_load_bus,
  input wire logic [1:0]  fabric_load_en,
  input wire logic [26:0] fabric_tap_readback_bus,
  input wire logic [1:0]  align_load_en,
  input wire logic [17:0] align_offset_bus,
  input wire logic [17:0] align_offset_out
);
  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  wr_latency_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after handshake");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before rready");
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  rd_unused_a: assert property (s_axi_rvalid |->
    s_axi_rdata[31:9] == 23'h0)
    else $error("unused read bits not zero");
  lane1_load_a: assert property (fabric_load_en[0]
    |=> $rose(s_axi_bvalid) ||
    fabric_tap_readback_bus[17:9] == $past(fabric_tap_load_bus[17:9]))
    else $error("lane 1 fabric load not applied");
  lane2_load_a: assert property (fabric_load_en[1]
    |=> $rose(s_axi_bvalid) ||
    fabric_tap_readback_bus[26:18] == $past(fabric_tap_load_bus[26:18]))
    else $error("lane 2 fabric load not applied");
  offset_keep_a: assert property (align_load_en == 2'h0
    |=> $stable(align_offset_out))
    else $error("alignment offset changed without its load");
  tap_keep_a: assert property (fabric_load_en == 2'h0 &&
    align_load_en == 2'h0
    |=> $rose(s_axi_bvalid) || $stable(fabric_tap_readback_bus))
    else $error("tap value moved with no cause");
  align_sum_a: assert property (align_load_en[0] &&
    !fabric_load_en[0] |=> $rose(s_axi_bvalid) ||
    fabric_tap_readback_bus[17:9] == $past(fabric_tap_readback_bus[17:9])
    - $past(align_offset_out[8:0]) + $past(align_offset_bus[8:0]))
    else $error("lane 1 tap does not track the alignment offset");
endmodule : nidly_regs_asserts

bind nidly_regs nidly_regs_asserts nidly_regs_asserts_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .fabric_tap_load_bus, .fabric_load_en,
  .fabric_tap_readback_bus, .align_load_en, .align_offset_bus,
  .align_offset_out
);

// ===== verification/nidly_regs_tb.sv
// Self-checking bench for the nibble input delay register bank.
`timescale 1ns/100ps
module nidly_regs_tb;
  typedef struct {
    logic [7:0]  addr;
    logic [31:0] wd;
    logic [8:0]  exp;
  } nidly_row_s;

  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, fabric_load_en, align_load_en, rs;
  logic [26:0] fabric_tap_load_bus, fabric_tap_readback_bus;
  logic [17:0] align_offset_bus, align_offset_out;
  logic [8:0]  e1, e2;
  int          err_total, checks_done;
  nidly_row_s  rows[21];
  logic [7:0]  bad[2] = '{8'h40, 8'h4e};

  nidly_regs nidly_regs_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fabric_tap_load_bus, .fabric_load_en,
    .fabric_tap_readback_bus, .align_load_en, .align_offset_bus,
    .align_offset_out
  );

  always #10 aclk = ~aclk;

  task automatic wrap_up;
    $display("Checks made %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      $display("ERROR %s expected %h seen %h", nm, ex, got);
      err_total++;
    end
  endtask : chk

  // The response ready is raised only after valid is seen, so the
  // slave must hold its answer for at least one cycle.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 100) begin
      err_total++;
      wrap_up();
    end
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 100) begin
      err_total++;
      wrap_up();
    end
    @(posedge aclk);
  endtask : axi_rd

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {fabric_load_en, align_load_en} = 4'h0;
    fabric_tap_load_bus = 27'h0;
    align_offset_bus = 18'h0;
    err_total = 0;
    checks_done = 0;
    {e1, e2} = 18'h0;
    // Action bits: step_up 15, step_down 14, coarse 13; coarse step (at 0x80) is 5, then 0x1fe.
    rows = '{'{8'h80, 32'h5, 9'h005}, '{8'h4c, 32'h1ff, 9'h1ff},
      '{8'h4c, 32'h80aa, 9'h000}, '{8'h4c, 32'h4000, 9'h1ff},
      '{8'h4c, 32'ha000, 9'h004}, '{8'h4c, 32'h6000, 9'h1ff},
      '{8'h4c, 32'hc0a5, 9'h0a5}, '{8'h4c, 32'h2123, 9'h123},
      '{8'h4c, 32'hffffffff, 9'h1ff}, '{8'h50, 32'h100, 9'h100},
      '{8'h50, 32'h8000, 9'h101}, '{8'h50, 32'h4000, 9'h100},
      '{8'h50, 32'ha000, 9'h105}, '{8'h50, 32'h6000, 9'h100},
      '{8'h50, 32'he0f0, 9'h0f0}, '{8'h50, 32'h0, 9'h000},
      '{8'h50, 32'h4000, 9'h1ff}, '{8'h50, 32'h8000, 9'h000},
      '{8'h80, 32'h1fe, 9'h1fe}, '{8'h50, 32'ha000, 9'h1fe},
      '{8'h50, 32'h6000, 9'h000}};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      axi_wr(rows[i].addr, rows[i].wd, rs);
      chk("bresp", 32'h0, {30'h0, rs});
      if (rows[i].addr == 8'h4c) e1 = rows[i].exp;
      if (rows[i].addr == 8'h50) e2 = rows[i].exp;
      axi_rd(rows[i].addr, rd, rs);
      chk("rdata", {23'h0, rows[i].exp}, rd);
      chk("rresp", 32'h0, {30'h0, rs});
      chk("readback", 32'({e2, e1, 9'h0}),
          32'(fabric_tap_readback_bus));
      chk("offset", 32'h0, {14'h0, align_offset_out});
    end
    axi_wr(8'h4c, 32'h100, rs);
    // Without the upper byte lane the action code is ignored.
    s_axi_wstrb <= 4'h1;
    axi_wr(8'h4c, 32'h40ff, rs);
    s_axi_wstrb <= 4'hf;
    axi_rd(8'h4c, rd, rs);
    chk("partial strobe", 32'h1ff, rd);
    align_offset_bus <= 18'h00010;
    align_load_en <= 2'h1;
    @(posedge aclk);
    align_load_en <= 2'h0;
    @(posedge aclk);
    chk("aligned tap", 32'h00f,
        32'(fabric_tap_readback_bus[17:9]));
    axi_wr(8'h4c, 32'h033, rs);
    axi_wr(8'h4c, 32'h8000, rs);
    axi_rd(8'h4c, rd, rs);
    chk("step after align", 32'h034, rd);
    chk("offset kept", 32'h10, {14'h0, align_offset_out});
    fabric_tap_load_bus <= {9'h0c3, 9'h0ab, 9'h000};
    fabric_load_en <= 2'h3;
    @(posedge aclk);
    fabric_load_en <= 2'h0;
    @(posedge aclk);
    axi_rd(8'h4c, rd, rs);
    chk("lane1 fabric", 32'h0ab, rd);
    axi_rd(8'h50, rd, rs);
    chk("lane2 fabric", 32'h0c3, rd);
    // Lane 2 offset moves alone; lane 1 keeps its tap and offset.
    align_offset_bus <= {9'h003, 9'h010};
    align_load_en <= 2'h2;
    @(posedge aclk);
    align_load_en <= 2'h0;
    @(posedge aclk);
    chk("lane2 aligned", 32'h0c6,
        32'(fabric_tap_readback_bus[26:18]));
    chk("lane2 offset", 32'h003, 32'(align_offset_out[17:9]));
    chk("lane1 offset", 32'h010, 32'(align_offset_out[8:0]));
    foreach (bad[i]) begin
      axi_wr(bad[i], 32'h1ff, rs);
      chk("bad bresp", 32'h2, {30'h0, rs});
      axi_rd(bad[i], rd, rs);
      chk("bad read", 32'h2, {rd[29:0], rs});
    end
    chk("lane1 untouched", 32'h0ab, 32'(fabric_tap_readback_bus[17:9]));
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(8'h4c, rd, rs);
    chk("lane1 reset", 32'h0, rd);
    axi_rd(8'h50, rd, rs);
    chk("lane2 reset", 32'h0, rd);
    axi_rd(8'h80, rd, rs);
    chk("coarse reset", 32'h0, rd);
    chk("offset reset", 32'h0, {14'h0, align_offset_out});
    wrap_up();
  end
endmodule : nidly_regs_tb
